/* File: sim/otrc_host.sv */
// host-side model issuing register reads and writes to the config bank
`timescale 1ns/10ps

module otrc_host
  import otrc_pkg::*;
(
  input wire logic ref_clk,
  output otrc_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  initial host_req = '0;

  // one-cycle strobe launched just after an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    host_req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge ref_clk);
    #1;
    // released address and data lines show the inverse and both strobes drop, so stale values cannot pass
    host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  // samples read data and valid just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    xfer(a, 1'b0, 8'h00);
    d = host_rdata;
    v = host_rvalid;
  endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the over-temperature config bank
`timescale 1ns/10ps
`include "otrc_params.svh"

module tb
  import otrc_pkg::*;
;
  // arbitrary value
  localparam logic [7:0] ID = 8'h3c;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  otrc_req_t host_req;
  logic [7:0] host_rdata;
  logic host_rvalid;
  logic [3:0] cpu_temp_upd = 4'h0;
  logic [31:0] cpu_temp_val = 32'h0;
  logic vtt_upd = 1'b0;
  logic [9:0] vtt_val = 10'h000;
  logic [2:0] timer_pins = 3'h0;
  otrc_hot_t hot_src = '0;
  logic stepping_en = 1'b0;
  logic [7:0] first_stepping_level = 8'h00;
  logic [23:0] max_duty = 24'h0;
  logic timer_input;
  logic overtemp_output;
  logic [3:0] active_step_size;
  logic [2:0] pwm_override;
  logic [23:0] pwm_override_duty;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'd55118;
  logic [31:0] r;
  logic [7:0] cfg1 = 8'h1c, cfg2 = 8'h07, sbc = 8'h00, ssp = 8'h00;
  logic [7:0] cpu [4] = '{default: 8'h80};
  logic [9:0] live = 10'h000, view = 10'h000;
  logic frz = 1'b0;
  logic [7:0] adr [12] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d,
    8'h1e, 8'h1f, 8'h33, 8'h40};

  always #5 ref_clk = ~ref_clk;

  otrc_host otrc_host_i (.ref_clk(ref_clk), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid));
  otrc_regs #(.PART_ID(ID)) otrc_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .cpu_temp_upd(cpu_temp_upd), .cpu_temp_val(cpu_temp_val), .vtt_upd(vtt_upd),
    .vtt_val(vtt_val), .timer_pins(timer_pins), .hot_src(hot_src), .stepping_en(stepping_en),
    .first_stepping_level(first_stepping_level), .max_duty(max_duty),
    .timer_input(timer_input), .overtemp_output(overtemp_output),
    .active_step_size(active_step_size), .pwm_override(pwm_override),
    .pwm_override_duty(pwm_override_duty));

  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  // read side effects: extended read freezes, upper byte read releases
  function automatic logic [7:0] mexp(input logic [7:0] a);
    logic [7:0] e;
    case (a)
      8'h16: e = cfg1;
      8'h17: e = cfg2;
      8'h18: e = sbc;
      8'h19: e = ssp;
      8'h1a, 8'h1b, 8'h1c: e = cpu[a - 8'h19];
      8'h33: e = cpu[0];
      8'h1d: e = ID;
      8'h1e: e = view[9:2];
      8'h1f: e = {2'b00, view[1:0], 4'h0};
      default: e = 8'h00;
    endcase
    if (a == 8'h1f) frz = 1'b1;
    if (a == 8'h1e) frz = 1'b0;
    if (!frz) view = live;
    return e;
  endfunction

  task automatic rdc(input logic [7:0] a);
    logic [7:0] d;
    logic v;
    otrc_host_i.rd(a, d, v);
    chk("host_rvalid", 32'd1, {31'd0, v});
    chk($sformatf("reg %h", a), {24'd0, mexp(a)}, {24'd0, d});
  endtask

  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    otrc_host_i.xfer(a, 1'b1, d);
    case (a)
      8'h16: cfg1 = d & `OTRC_MASK_CFG1;
      8'h17: cfg2 = d & `OTRC_MASK_CFG2;
      8'h18: sbc = d;
      8'h19: ssp = d;
      default: ;
    endcase
  endtask

  task automatic ldv(input logic [9:0] v);
    vtt_val = v;
    vtt_upd = 1'b1;
    @(posedge ref_clk);
    #1;
    vtt_upd = 1'b0;
    live = v;
    if (!frz) view = v;
  endtask

  // expectation from inputs held across the next edge
  task automatic outc(input logic hold);
    logic [4:0] h;
    logic ot;
    logic tin;
    logic [3:0] st;
    logic [23:0] du;
    h = hot_src;
    ot = h[4] | h[3] | h[2] | (h[1] & cfg1[5]) | (h[0] & cfg1[6]);
    tin = (cfg1[1:0] == 2'b00) ? 1'b0 : timer_pins[cfg1[1:0] - 2'd1];
    st = h[4] ? sbc[3:0] : h[3] ? sbc[7:4] : h[2] ? ssp[3:0] :
      (h[1] & cfg1[5]) ? ssp[7:4] : 4'h0;
    for (int n = 0; n < 3; n++)
      du[8*n +: 8] = !(ot & cfg2[n]) ? 8'h00 : stepping_en ? first_stepping_level :
        cfg1[2+n] ? 8'hff : max_duty[8*n +: 8];
    @(posedge ref_clk);
    #1;
    chk("timer_input", {31'd0, tin}, {31'd0, timer_input});
    chk("overtemp_output", {31'd0, ot}, {31'd0, overtemp_output});
    chk("active_step_size", {28'd0, st}, {28'd0, active_step_size});
    chk("pwm_override", {29'd0, cfg2[2:0] & {3{ot}}}, {29'd0, pwm_override});
    chk("pwm_override_duty", {8'd0, du}, {8'd0, pwm_override_duty});
    // low enable must hold timer_input, overtemp_output and pwm_override_duty although the inputs move
    if (hold)
    begin
      clk_en = 1'b0;
      hot_src = ~hot_src;
      timer_pins = ~timer_pins;
      @(posedge ref_clk);
      #1;
      clk_en = 1'b1;
      chk("held timer_input", {31'd0, tin}, {31'd0, timer_input});
      chk("held overtemp_output", {31'd0, ot}, {31'd0, overtemp_output});
      chk("held pwm_override_duty", {8'd0, du}, {8'd0, pwm_override_duty});
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    outc(1'b0);
    foreach (adr[i]) rdc(adr[i]);
    foreach (adr[i])
    begin
      r = rnd();
      wrm(adr[i], r[7:0]);
    end
    foreach (adr[i]) rdc(adr[i]);
    // per-channel strobes, so a partial mask must leave the others alone
    repeat (2)
    begin
      r = rnd();
      cpu_temp_val = rnd();
      cpu_temp_upd = r[3:0];
      @(posedge ref_clk);
      #1;
      cpu_temp_upd = 4'h0;
      for (int n = 0; n < 4; n++)
        if (r[n]) cpu[n] = cpu_temp_val[8*n +: 8];
      for (int i = 4; i < 7; i++) rdc(adr[i]);
      rdc(8'h33);
    end
    r = rnd();
    ldv(r[9:0]);
    rdc(8'h1f);
    ldv(r[19:10]);
    rdc(8'h1e);
    rdc(8'h1f);
    rdc(8'h1e);
    repeat (40)
    begin
      r = rnd();
      wrm(8'h16, r[7:0]);
      wrm(8'h17, r[15:8]);
      wrm(8'h18, r[23:16]);
      wrm(8'h19, r[31:24]);
      r = rnd();
      hot_src = r[4:0];
      timer_pins = r[7:5];
      stepping_en = r[8] & r[9];
      first_stepping_level = r[23:16];
      max_duty = {r[31:24], r[15:8], ~r[23:16]};
      outc(r[12]);
      rdc(8'h16 + {6'd0, r[11:10]});
    end
    // mid-run reset must bring back every reset value, readings included
    rst_b = 1'b0;
    @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    cfg1 = 8'h1c;
    cfg2 = 8'h07;
    sbc = 8'h00;
    ssp = 8'h00;
    cpu = '{default: 8'h80};
    live = 10'h000;
    view = 10'h000;
    frz = 1'b0;
    outc(1'b0);
    foreach (adr[i]) rdc(adr[i]);
    complete_run();
  end
endmodule

/* File: verilog/otrc_params.svh */
// offsets, field positions and reset values of the over-temperature config bank
`ifndef OTRC_PARAMS_SVH
`define OTRC_PARAMS_SVH

`define OTRC_ADDR_CFG1 8'h16
`define OTRC_ADDR_CFG2 8'h17
`define OTRC_ADDR_STEP_BC 8'h18
`define OTRC_ADDR_STEP_SP 8'h19
`define OTRC_ADDR_CPU1 8'h1a
`define OTRC_ADDR_CPU2 8'h1b
`define OTRC_ADDR_CPU3 8'h1c
`define OTRC_ADDR_ID 8'h1d
`define OTRC_ADDR_VTT_MSB 8'h1e
`define OTRC_ADDR_EXT3 8'h1f
`define OTRC_ADDR_CPU0 8'h33

`define OTRC_RST_CFG1 8'h1c
`define OTRC_RST_CFG2 8'h07
`define OTRC_RST_STEP 8'h00
`define OTRC_RST_CPU 8'h80
`define OTRC_RST_VTT 10'h000

`define OTRC_MASK_CFG1 8'h7f
`define OTRC_MASK_CFG2 8'h07

`define OTRC_TMR_SEL_LSB 0
`define OTRC_FULL_LSB 2
`define OTRC_PUSH_EN_BIT 5
`define OTRC_SLAVE_EN_BIT 6
`define OTRC_RESPOND_LSB 0
`define OTRC_FULL_DUTY 8'hff

`endif

/* File: verilog/otrc_pkg.sv */
// types shared by the over-temperature config bank
package otrc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } otrc_req_t;

  typedef struct packed {
    logic bus_master;
    logic cpu_ctrl;
    logic diode;
    logic pushed;
    logic slave;
  } otrc_hot_t;

  typedef enum logic [1:0] {
    OTRC_SRC_BUS = 2'b00,
    OTRC_SRC_CPU = 2'b01,
    OTRC_SRC_DIODE = 2'b10,
    OTRC_SRC_PUSH = 2'b11
  } otrc_src_t;

endpackage

/* File: verilog/otrc_regs.sv */
// over-temperature response configuration registers and readback
//
// Behaviour
// - timer pin select: 00 disables timer input, other codes route one pin each
// - per pwm full-drive bit: set gives 100% duty, clear gives channel maximum
// - bit 5 lets pushed temperatures assert the over-temperature output
// - bit 6 lets bus slave temperatures assert the over-temperature output
// - second config bits 0..2 enable each pwm to react to events
// - third config low nibble is step size for bus master assertions
// - third config high nibble is step size for cpu control assertions
// - fourth config low nibble is step size for diode sensor assertions
// - fourth config high nibble is step size for pushed temperature assertions
// - four read-only cpu temperature readings reset to 0x80
// - id register at 0x1d returns fixed code, writes ignored
// - vtt upper eight bits read-only, reset zero
// - extended register bits 5:4 hold vtt two lsbs, rest reserved
// - reading extended bits freezes them and vtt msb until msb read
// - with stepping enabled first stepping level gives duty on assertion
`timescale 1ns/10ps
`include "otrc_params.svh"

module otrc_regs
  import otrc_pkg::*;
#(
  // arbitrary neutral value, not a real part code
  parameter logic [7:0] PART_ID = 8'h5a
)
(
  input logic ref_clk,
  input logic rst_b,
  input logic clk_en,
  input otrc_req_t host_req,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input logic [3:0] cpu_temp_upd,
  input logic [31:0] cpu_temp_val,
  input logic vtt_upd,
  input logic [9:0] vtt_val,
  input logic [2:0] timer_pins,
  input otrc_hot_t hot_src,
  input logic stepping_en,
  input logic [7:0] first_stepping_level,
  input logic [23:0] max_duty,
  output logic timer_input,
  output logic overtemp_output,
  output logic [3:0] active_step_size,
  output logic [2:0] pwm_override,
  output logic [23:0] pwm_override_duty
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [7:0] step_bc;
  logic [7:0] step_sp;
  logic [7:0] cpu_temp [4];
  logic [9:0] vtt_live;
  logic [9:0] vtt_shown;
  logic vtt_frozen;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire hit_cfg1 = host_req.addr == `OTRC_ADDR_CFG1;
  wire hit_cfg2 = host_req.addr == `OTRC_ADDR_CFG2;
  wire hit_step_bc = host_req.addr == `OTRC_ADDR_STEP_BC;
  wire hit_step_sp = host_req.addr == `OTRC_ADDR_STEP_SP;
  wire hit_vtt_msb = host_req.addr == `OTRC_ADDR_VTT_MSB;
  wire hit_ext3 = host_req.addr == `OTRC_ADDR_EXT3;
  wire wr_cfg1 = clk_en & host_req.wr & hit_cfg1;
  wire wr_cfg2 = clk_en & host_req.wr & hit_cfg2;
  wire wr_step_bc = clk_en & host_req.wr & hit_step_bc;
  wire wr_step_sp = clk_en & host_req.wr & hit_step_sp;
  wire rd_msb = clk_en & host_req.rd & hit_vtt_msb;
  wire rd_ext = clk_en & host_req.rd & hit_ext3;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [7:0] vtt_msb_view = vtt_shown[9:2];
  wire [7:0] ext3_view = {2'b00, vtt_shown[1:0], 4'h0};
  wire [7:0] next_rdata =
    hit_cfg1 ? cfg1 :
    hit_cfg2 ? cfg2 :
    hit_step_bc ? step_bc :
    hit_step_sp ? step_sp :
    (host_req.addr == `OTRC_ADDR_CPU0) ? cpu_temp[0] :
    (host_req.addr == `OTRC_ADDR_CPU1) ? cpu_temp[1] :
    (host_req.addr == `OTRC_ADDR_CPU2) ? cpu_temp[2] :
    (host_req.addr == `OTRC_ADDR_CPU3) ? cpu_temp[3] :
    (host_req.addr == `OTRC_ADDR_ID) ? PART_ID :
    hit_vtt_msb ? vtt_msb_view :
    hit_ext3 ? ext3_view :
    8'h00;

  // ------------------------------------------------------------
  // host writable configuration
  // ------------------------------------------------------------
  // id, readings and reserved bits have no host write path
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cfg1 <= `OTRC_RST_CFG1;
      cfg2 <= `OTRC_RST_CFG2;
      step_bc <= `OTRC_RST_STEP;
      step_sp <= `OTRC_RST_STEP;
    end
    else
    begin
      if (wr_cfg1)
        cfg1 <= host_req.wdata & `OTRC_MASK_CFG1;
      if (wr_cfg2)
        cfg2 <= host_req.wdata & `OTRC_MASK_CFG2;
      if (wr_step_bc)
        step_bc <= host_req.wdata;
      if (wr_step_sp)
        step_sp <= host_req.wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      host_rvalid <= host_req.rd;
      if (host_req.rd)
        host_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // cpu temperature readings
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_cpu
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          cpu_temp[ch] <= `OTRC_RST_CPU;
        else if (clk_en && cpu_temp_upd[ch])
          cpu_temp[ch] <= cpu_temp_val[ch*8 +: 8];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // vtt reading with read freeze
  // ------------------------------------------------------------
  // live keeps converting while frozen, so the view catches up on release
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      vtt_live <= `OTRC_RST_VTT;
      vtt_shown <= `OTRC_RST_VTT;
      vtt_frozen <= 1'b0;
    end
    else if (clk_en)
    begin
      if (vtt_upd)
        vtt_live <= vtt_val;
      if (!vtt_frozen && !rd_ext)
        vtt_shown <= vtt_live;
      if (rd_ext)
        vtt_frozen <= 1'b1;
      else if (rd_msb)
        vtt_frozen <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // over-temperature response
  // ------------------------------------------------------------
  wire [1:0] tmr_sel = cfg1[`OTRC_TMR_SEL_LSB +: 2];
  wire next_timer = (tmr_sel == 2'b00) ? 1'b0 : timer_pins[tmr_sel - 2'd1];
  wire push_gated = hot_src.pushed & cfg1[`OTRC_PUSH_EN_BIT];
  wire slave_gated = hot_src.slave & cfg1[`OTRC_SLAVE_EN_BIT];
  wire next_hot = hot_src.bus_master | hot_src.cpu_ctrl | hot_src.diode
    | push_gated | slave_gated;
  // fixed priority when sources overlap; slave assertions use no stepping
  otrc_src_t src_sel;
  assign src_sel =
    hot_src.bus_master ? OTRC_SRC_BUS :
    hot_src.cpu_ctrl ? OTRC_SRC_CPU :
    hot_src.diode ? OTRC_SRC_DIODE : OTRC_SRC_PUSH;
  wire src_any = hot_src.bus_master | hot_src.cpu_ctrl | hot_src.diode | push_gated;
  logic [3:0] next_step;
  always_comb
  begin
    next_step = 4'h0;
    case (src_sel)
      OTRC_SRC_BUS: next_step = step_bc[3:0];
      OTRC_SRC_CPU: next_step = step_bc[7:4];
      OTRC_SRC_DIODE: next_step = step_sp[3:0];
      OTRC_SRC_PUSH: next_step = step_sp[7:4];
      default: next_step = 4'h0;
    endcase
    if (!src_any)
      next_step = 4'h0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      timer_input <= 1'b0;
      overtemp_output <= 1'b0;
      active_step_size <= 4'h0;
    end
    else if (clk_en)
    begin
      timer_input <= next_timer;
      overtemp_output <= next_hot;
      active_step_size <= next_step;
    end
  end

  genvar pw;
  generate
    for (pw = 0; pw < 3; pw++)
    begin : g_pwm
      wire respond = next_hot & cfg2[`OTRC_RESPOND_LSB + pw];
      wire full = cfg1[`OTRC_FULL_LSB + pw];
      wire [7:0] next_duty = stepping_en ? first_stepping_level :
        full ? `OTRC_FULL_DUTY : max_duty[pw*8 +: 8];
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
        begin
          pwm_override[pw] <= 1'b0;
          pwm_override_duty[pw*8 +: 8] <= 8'h00;
        end
        else if (clk_en)
        begin
          pwm_override[pw] <= respond;
          pwm_override_duty[pw*8 +: 8] <= respond ? next_duty : 8'h00;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  wire others_cold = !hot_src.bus_master && !hot_src.cpu_ctrl && !hot_src.diode;

  timer_disabled_a: assert property (clk_en && tmr_sel == 2'b00 |=> !timer_input)
    else $error("timer input active while disabled");
  timer_route_a: assert property (clk_en && tmr_sel != 2'b00
    |=> timer_input == $past(timer_pins[tmr_sel - 2'd1]))
    else $error("timer input not routed from selected pin");
  full_duty_a: assert property (clk_en && !stepping_en && cfg1[2] && cfg2[0] && next_hot
    |=> pwm_override[0] && pwm_override_duty[7:0] == 8'hff)
    else $error("channel one not at full duty");
  max_duty_a: assert property (clk_en && !stepping_en && !cfg1[3] && cfg2[1] && next_hot
    |=> pwm_override_duty[15:8] == $past(max_duty[15:8]))
    else $error("channel two not at programmed maximum");
  push_block_a: assert property (clk_en && others_cold && !hot_src.slave
    && !cfg1[5] |=> !overtemp_output)
    else $error("pushed value asserted output while blocked");
  slave_block_a: assert property (clk_en && others_cold && !hot_src.pushed
    && hot_src.slave |=> overtemp_output == $past(cfg1[6]))
    else $error("slave temperature gating wrong");
  respond_off_a: assert property (clk_en && !cfg2[2] |=> !pwm_override[2])
    else $error("channel three reacted while disabled");
  step_bus_a: assert property (clk_en && hot_src.bus_master
    |=> active_step_size == $past(step_bc[3:0]))
    else $error("bus master step size wrong");
  step_cpu_a: assert property (clk_en && !hot_src.bus_master && hot_src.cpu_ctrl
    |=> active_step_size == $past(step_bc[7:4]))
    else $error("cpu control step size wrong");
  step_diode_a: assert property (clk_en && !hot_src.bus_master && !hot_src.cpu_ctrl
    && hot_src.diode |=> active_step_size == $past(step_sp[3:0]))
    else $error("diode step size wrong");
  step_push_a: assert property (clk_en && others_cold && push_gated
    |=> active_step_size == $past(step_sp[7:4]))
    else $error("pushed step size wrong");
  cpu_reset_a: assert property ($rose(rst_b) |-> cpu_temp[0] == 8'h80
    && cpu_temp[3] == 8'h80)
    else $error("cpu reading not 0x80 after reset");
  id_read_a: assert property (clk_en && host_req.rd && host_req.addr == 8'h1d
    |=> host_rvalid && host_rdata == PART_ID)
    else $error("id read wrong");
  ext_reserved_a: assert property (clk_en && host_req.rd && hit_ext3
    |=> host_rdata[7:6] == 2'b00 && host_rdata[3:0] == 4'h0)
    else $error("reserved extended bits not zero");
  freeze_hold_a: assert property (clk_en && vtt_frozen && !rd_msb
    |=> $stable(vtt_shown))
    else $error("vtt view changed while frozen");
  freeze_set_a: assert property (rd_ext |=> vtt_frozen[*2] ##0 $stable(vtt_shown)
    or (vtt_frozen ##1 !vtt_frozen))
    else $error("extended read did not freeze");
  step_level_a: assert property (clk_en && stepping_en && cfg2[1] && next_hot
    |=> pwm_override_duty[15:8] == $past(first_stepping_level))
    else $error("stepping level not applied");
  cfg2_mask_a: assert property (wr_cfg2 |=> cfg2[7:3] == 5'h00
    ##1 cfg2[7:3] == 5'h00)
    else $error("reserved config bits took a write");
  cfg1_mask_a: assert property (wr_cfg1 |=> !cfg1[7])
    else $error("reserved bit 7 took a write");
  // enable low must freeze outputs, config and readings alike
  enable_hold_a: assert property (!clk_en |=> $stable(overtemp_output)
    && $stable(pwm_override_duty) && $stable(cfg1) && $stable(cpu_temp[0]))
    else $error("state moved while clock enable low");
  rdata_hold_a: assert property (clk_en && !host_req.rd
    |=> !host_rvalid && $stable(host_rdata))
    else $error("read data changed without a read");
  respond_on_a: assert property (clk_en && cfg2[2] && next_hot |=> pwm_override[2])
    else $error("channel three ignored an enabled event");
  step_none_a: assert property (clk_en && others_cold && !push_gated
    |=> active_step_size == 4'h0)
    else $error("step size shown with no stepping source");
  cpu_update_a: assert property (clk_en && cpu_temp_upd[1]
    |=> cpu_temp[1] == $past(cpu_temp_val[15:8]))
    else $error("cpu reading not loaded");
  cpu_hold_a: assert property (!(clk_en && cpu_temp_upd[3]) |=> $stable(cpu_temp[3]))
    else $error("cpu reading moved without an update");
  vtt_reset_a: assert property ($rose(rst_b) |-> vtt_shown == 10'h000
    && !vtt_frozen)
    else $error("vtt reading not zero after reset");
  vtt_follow_a: assert property (clk_en && !vtt_frozen && !rd_ext
    |=> vtt_shown == $past(vtt_live))
    else $error("vtt view did not follow the live value");

  freeze_cycle_c: cover property (rd_ext ##[1:20] rd_msb);
  overtemp_full_c: cover property (pwm_override[0] && pwm_override_duty[7:0] == 8'hff);
  push_hot_c: cover property (clk_en && push_gated ##1 overtemp_output);
  timer_pin3_c: cover property (tmr_sel == 2'b11 && timer_input);
  step_level_c: cover property (stepping_en && pwm_override[1]);

endmodule
